// >>> dld_fifo_top.sv
// Dual line delay FIFO: write side on clk, read side on read_clock
//
// Functional notes
// - Two FIFO line memories, 5120 by 8 each
// - Write enable low stores byte, advances counter
// - Write enable high: no store, counter holds
// - Write reset low returns write counter home
// - Read enable low drives both outputs, advances
// - One-line output byte copied into second memory
// - Read enable high: no read, outputs float
// - Read enable high also stops second-memory writes
// - Read reset low clears three read-side counters
// - Write and read sides run on separate clocks
// - Sampled byte committed on the following edge
`timescale 1ns/100ps
`default_nettype none

module dld_fifo_top #(
  parameter int WIDTH = dld_pkg::LINE_WIDTH,
  parameter int DEPTH = dld_pkg::LINE_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             write_enable_n,
  input  wire logic             write_counter_reset_n,
  input  wire logic [WIDTH-1:0] input_byte,
  input  wire logic             read_clock,
  input  wire logic             read_enable_n,
  input  wire logic             read_counter_reset_n,
  output logic      [WIDTH-1:0] one_line_out_byte,
  output logic                  one_line_out_oe,
  output logic      [WIDTH-1:0] two_line_out_byte,
  output logic                  two_line_out_oe
);
  import dld_pkg::*;

  localparam int          AW       = $clog2(DEPTH);
  localparam logic [AW-1:0] PTR_INIT = '0;
  localparam logic [AW-1:0] PTR_ONE  = AW'(1);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  // Refuse geometries the pointer logic cannot serve
  if (DEPTH < MIN_DEPTH) begin : g_bad_depth
    $error("DEPTH must be at least two words");
  end
  if (WIDTH < MIN_WIDTH) begin : g_bad_width
    $error("WIDTH must be at least one bit");
  end

  // Circular address step, wrapping after the last word of a line
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == PTR_LAST) ? PTR_INIT : p + PTR_ONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write side, clocked by clk only

  logic [AW-1:0] wr1_ptr_q;
  logic [AW-1:0] wr1_ptr_d;
  logic          wr1_store;

  // Store only when enabled and the counter is not being reset
  assign wr1_store = !reset && !write_enable_n
                     && write_counter_reset_n;

  // First-line write counter
  always_comb begin
    wr1_ptr_d = wr1_ptr_q;
    if (reset || !write_counter_reset_n) begin
      wr1_ptr_d = PTR_INIT;
    end else if (!write_enable_n) begin
      wr1_ptr_d = ptr_inc(wr1_ptr_q);
    end
  end

  always_ff @(posedge clk) begin
    wr1_ptr_q <= wr1_ptr_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset crossing into the read domain

  logic [SYNC_STAGES-1:0] rd_rst_sync_q;
  logic [SYNC_STAGES-1:0] rd_rst_sync_d;
  logic                   rd_reset;

  // Level crossing: first stage feeds only the second
  always_comb begin
    rd_rst_sync_d = {rd_rst_sync_q[SYNC_STAGES-2:0], reset};
  end

  always_ff @(posedge read_clock) begin
    rd_rst_sync_q <= rd_rst_sync_d;
  end

  assign rd_reset = rd_rst_sync_q[SYNC_STAGES-1];

  ////////////////////////////////////////////////////////////////////////////
  // Read side counters, clocked by read_clock only

  logic [AW-1:0] rd1_ptr_q;
  logic [AW-1:0] rd1_ptr_d;
  logic [AW-1:0] rd2_ptr_q;
  logic [AW-1:0] rd2_ptr_d;
  logic [AW-1:0] wr2_ptr_q;
  logic [AW-1:0] wr2_ptr_d;
  logic          rd_active;
  logic          wr2_store;

  // A read cycle is any edge out of read-side reset with read enable low
  assign rd_active = !rd_reset && !read_enable_n;
  // Second memory takes the copy unless its counter is reset
  assign wr2_store = rd_active && read_counter_reset_n;

  // Read counters of both memories and write counter of the second
  always_comb begin
    rd1_ptr_d = rd1_ptr_q;
    rd2_ptr_d = rd2_ptr_q;
    wr2_ptr_d = wr2_ptr_q;
    if (rd_reset || !read_counter_reset_n) begin
      rd1_ptr_d = PTR_INIT;
      rd2_ptr_d = PTR_INIT;
      wr2_ptr_d = PTR_INIT;
    end else if (!read_enable_n) begin
      rd1_ptr_d = ptr_inc(rd1_ptr_q);
      rd2_ptr_d = ptr_inc(rd2_ptr_q);
      wr2_ptr_d = ptr_inc(wr2_ptr_q);
    end
  end

  always_ff @(posedge read_clock) begin
    rd1_ptr_q <= rd1_ptr_d;
    rd2_ptr_q <= rd2_ptr_d;
    wr2_ptr_q <= wr2_ptr_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // The two line memories

  logic [WIDTH-1:0] line1_rd_data;
  logic [WIDTH-1:0] line2_rd_data;

  // First line: written on clk, read on read_clock; the reader keeps
  // its distance from the writer, so the read word is settled
  dld_line_mem #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_line1 (
    .wr_clk  (clk),
    .wr_reset(reset),
    .wr_en   (wr1_store),
    .wr_addr (wr1_ptr_q),
    .wr_data (input_byte),
    .rd_addr (rd1_ptr_q),
    .rd_data (line1_rd_data)
  );

  // Second line: filled with the one-line byte being output
  dld_line_mem #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_line2 (
    .wr_clk  (read_clock),
    .wr_reset(rd_reset),
    .wr_en   (wr2_store),
    .wr_addr (wr2_ptr_q),
    .wr_data (line1_rd_data),
    .rd_addr (rd2_ptr_q),
    .rd_data (line2_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output registers and three-state enables

  logic [WIDTH-1:0] out1_q;
  logic [WIDTH-1:0] out1_d;
  logic [WIDTH-1:0] out2_q;
  logic [WIDTH-1:0] out2_d;
  logic             oe_q;
  logic             oe_d;

  // Drive fresh bytes on a read cycle, float the pins otherwise
  always_comb begin
    out1_d = out1_q;
    out2_d = out2_q;
    oe_d   = rd_active;
    if (rd_active) begin
      out1_d = line1_rd_data;
      out2_d = line2_rd_data;
    end
    if (rd_reset) begin
      out1_d = '0;
      out2_d = '0;
    end
  end

  always_ff @(posedge read_clock) begin
    out1_q <= out1_d;
    out2_q <= out2_d;
    oe_q   <= oe_d;
  end

  assign one_line_out_byte = out1_q;
  assign two_line_out_byte = out2_q;
  assign one_line_out_oe   = oe_q;
  assign two_line_out_oe   = oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Write side checks

  a_wr_advance: assert property (
    @(posedge clk) disable iff (reset)
    (!write_enable_n && write_counter_reset_n)
      |=> (wr1_ptr_q == (($past(wr1_ptr_q) == PTR_LAST)
                         ? PTR_INIT : $past(wr1_ptr_q) + PTR_ONE))
  ) else $error("Write counter did not step on an enabled edge");

  a_wr_hold: assert property (
    @(posedge clk) disable iff (reset)
    (write_enable_n && write_counter_reset_n) |=> $stable(wr1_ptr_q)
  ) else $error("Write counter moved while write disabled");

  a_wr_reset: assert property (
    @(posedge clk) disable iff (reset)
    !write_counter_reset_n |=> (wr1_ptr_q == PTR_INIT)
  ) else $error("Write counter not home after write reset");

  a_wr_reset_wins: assert property (
    @(posedge clk) disable iff (reset)
    (!write_counter_reset_n && !write_enable_n)
      |-> !wr1_store ##1 (wr1_ptr_q == PTR_INIT)
  ) else $error("Write enable overrode the counter reset");

  ////////////////////////////////////////////////////////////////////////////
  // Read side checks

  sequence s_read_cycle;
    !read_enable_n && read_counter_reset_n;
  endsequence

  sequence s_idle_cycle;
    read_enable_n && read_counter_reset_n;
  endsequence

  // Case equality: the second line is still unwritten on the first pass
  a_rd_drive: assert property (
    @(posedge read_clock) disable iff (reset || rd_reset)
    s_read_cycle |=> (one_line_out_oe && two_line_out_oe
                      && one_line_out_byte === $past(line1_rd_data)
                      && two_line_out_byte === $past(line2_rd_data))
  ) else $error("Read cycle did not drive the addressed bytes");

  a_rd_copy: assert property (
    @(posedge read_clock) disable iff (reset || rd_reset)
    s_read_cycle |-> wr2_store && (wr2_ptr_q == rd1_ptr_q)
      ##1 (wr2_ptr_q == rd1_ptr_q)
  ) else $error("Second memory copy out of step with first read");

  a_rd_float: assert property (
    @(posedge read_clock) disable iff (reset || rd_reset)
    s_idle_cycle |=> (!one_line_out_oe && !two_line_out_oe
                      && $stable(rd1_ptr_q) && $stable(rd2_ptr_q))
  ) else $error("Outputs or read counters active while disabled");

  a_rd_no_copy: assert property (
    @(posedge read_clock) disable iff (reset || rd_reset)
    s_idle_cycle |-> !wr2_store ##1 $stable(wr2_ptr_q)
  ) else $error("Second memory written while read disabled");

  a_rd_reset: assert property (
    @(posedge read_clock) disable iff (reset || rd_reset)
    !read_counter_reset_n |=> (rd1_ptr_q == PTR_INIT
                               && rd2_ptr_q == PTR_INIT
                               && wr2_ptr_q == PTR_INIT)
  ) else $error("Read-side counters not home after read reset");

  a_ptr_range: assert property (
    @(posedge read_clock) disable iff (reset || rd_reset)
    (rd1_ptr_q <= PTR_LAST) && (rd2_ptr_q == wr2_ptr_q)
  ) else $error("Read pointer out of line or lines out of step");

  a_rd_reset_wins: assert property (
    @(posedge read_clock) disable iff (reset || rd_reset)
    (!read_counter_reset_n && !read_enable_n)
      |-> !wr2_store ##1 (wr2_ptr_q == PTR_INIT)
  ) else $error("Read enable overrode the read counter reset");

  a_rd_idle_gate: assert property (
    @(posedge read_clock) disable iff (reset || rd_reset)
    read_enable_n |-> !wr2_store
  ) else $error("Second memory store enabled with reads off");

  // Write side gate, independent of the counter checks above
  a_wr_no_store: assert property (
    @(posedge clk) disable iff (reset)
    write_enable_n |-> !wr1_store
  ) else $error("First line stored while write disabled");

endmodule
`default_nettype wire

// >>> dld_fifo_top_tb.sv
// Self-checking bench for the dual line delay FIFO
`timescale 1ns/100ps
`default_nettype none

module dld_fifo_top_tb;
  import dld_pkg::*;

  localparam int DEPTH = 8;
  localparam int LINES = 6;

  logic      clk, reset, write_enable_n, write_counter_reset_n;
  logic      read_clock, read_enable_n, read_counter_reset_n;
  logic      one_line_out_oe, two_line_out_oe;
  dld_byte_t input_byte, one_line_out_byte, two_line_out_byte;
  dld_byte_t one_pin, two_pin, exp1, exp2;
  dld_byte_t ref1 [DEPTH];
  dld_byte_t ref2 [DEPTH];
  bit        valid2 [DEPTH];
  bit        pend, pend2;
  int        wptr, rptr, failures, checked, cycles;

  //////////////////////////////////////////////////////////////////////////
  dld_fifo_top #(.WIDTH(LINE_WIDTH), .DEPTH(DEPTH)) uut (
    .clk                   (clk),
    .reset                 (reset),
    .write_enable_n        (write_enable_n),
    .write_counter_reset_n (write_counter_reset_n),
    .input_byte            (input_byte),
    .read_clock            (read_clock),
    .read_enable_n         (read_enable_n),
    .read_counter_reset_n  (read_counter_reset_n),
    .one_line_out_byte     (one_line_out_byte),
    .one_line_out_oe       (one_line_out_oe),
    .two_line_out_byte     (two_line_out_byte),
    .two_line_out_oe       (two_line_out_oe)
  );

  dld_pin_model pins (
    .one_oe   (one_line_out_oe),
    .one_byte (one_line_out_byte),
    .two_oe   (two_line_out_oe),
    .two_byte (two_line_out_byte),
    .one_pin  (one_pin),
    .two_pin  (two_pin)
  );

  //////////////////////////////////////////////////////////////////////////
  // Write clock 50 ns, read clock 160 ns with an odd phase offset
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    read_clock = 1'b0;
    #37;
    forever #80 read_clock = ~read_clock;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      end_of_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Compare one value, count and report
  task automatic check(input string what, input dld_byte_t seen,
                       input dld_byte_t exp);
    checked = checked + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Next model address, wrapping after the last word of a line
  function automatic int ptr_next(input int p);
    return (p + 1) % DEPTH;
  endfunction

  // One write-side cycle plus its expected effect on the line memory
  task automatic wr(input logic we_n, input logic wrst_n, input dld_byte_t d);
    @(posedge clk);
    write_enable_n <= we_n;
    write_counter_reset_n <= wrst_n;
    input_byte <= d;
    if (!wrst_n) begin
      wptr = 0;
    end else if (!we_n) begin
      ref1[wptr] = d;
      wptr = ptr_next(wptr);
    end
  endtask

  // One read-side cycle; checks what the previous cycle produced
  task automatic rd(input logic re_n, input logic rrst_n);
    @(posedge read_clock);
    read_enable_n <= re_n;
    read_counter_reset_n <= rrst_n;
    @(negedge read_clock);
    if (pend) begin
      check("one_line_out_byte", one_pin, exp1);
      if (pend2) check("two_line_out_byte", two_pin, exp2);
    end else begin
      check("one_line_pin", one_pin, 'z);
      check("two_line_pin", two_pin, 'z);
    end
    pend = !re_n;
    pend2 = pend && valid2[rptr];
    exp1 = ref1[rptr];
    exp2 = ref2[rptr];
    if (!re_n && rrst_n) begin
      ref2[rptr] = ref1[rptr];
      valid2[rptr] = 1'b1;
      rptr = ptr_next(rptr);
    end
    if (!rrst_n) rptr = 0;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence: lines written whole, then read back, both sides with gaps
  initial begin
    int  k;
    bit  gap;
    {failures, checked, cycles, wptr, rptr} = '0;
    {pend, pend2} = 2'b00;
    reset = 1'b1;
    write_enable_n = 1'b1;
    write_counter_reset_n = 1'b1;
    input_byte = 8'h00;
    read_enable_n = 1'b1;
    read_counter_reset_n = 1'b1;
    void'($urandom(77255));
    repeat (4) @(posedge read_clock);
    @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge read_clock);
    wr(1'b1, 1'b0, 8'h00);
    rd(1'b1, 1'b0);
    for (int ln = 0; ln < LINES; ln++) begin
      if (ln == 2) begin
        for (k = 0; k < 3; k++) wr(1'b0, 1'b1, dld_byte_t'($urandom));
        wr(1'b0, 1'b0, 8'hff);
      end
      k = 0;
      while (k < DEPTH) begin
        gap = ($urandom_range(3, 0) == 0);
        wr(gap, 1'b1, dld_byte_t'($urandom));
        if (!gap) k++;
      end
      wr(1'b1, 1'b1, 8'h00);
      wr(1'b1, 1'b1, 8'h00);
      if (ln == 3) begin
        for (k = 0; k < 3; k++) rd(1'b0, 1'b1);
        rd(1'b0, 1'b0);
      end
      k = 0;
      while (k < DEPTH) begin
        gap = ($urandom_range(3, 0) == 0);
        rd(gap, 1'b1);
        if (!gap) k++;
      end
      rd(1'b1, 1'b1);
    end
    rd(1'b1, 1'b1);
    end_of_test();
  end
endmodule

`default_nettype wire

// >>> dld_line_mem.sv
// One line memory: pipelined write port, asynchronous read port
`timescale 1ns/100ps
`default_nettype none

module dld_line_mem #(
  parameter int WIDTH = dld_pkg::LINE_WIDTH,
  parameter int DEPTH = dld_pkg::LINE_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             wr_clk,
  input  wire logic             wr_reset,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  import dld_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Storage and pending write

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic             pend_q;
  logic             pend_d;
  logic [AW-1:0]    pend_addr_q;
  logic [AW-1:0]    pend_addr_d;
  logic [WIDTH-1:0] pend_data_q;
  logic [WIDTH-1:0] pend_data_d;

  // Sample the byte now, commit it on the next edge
  always_comb begin
    pend_d      = wr_en;
    pend_addr_d = wr_en ? wr_addr : pend_addr_q;
    pend_data_d = wr_en ? wr_data : pend_data_q;
    if (wr_reset) begin
      pend_d = 1'b0;
    end
  end

  // The pending byte only lands if one more edge arrives
  always_ff @(posedge wr_clk) begin
    pend_q      <= pend_d;
    pend_addr_q <= pend_addr_d;
    pend_data_q <= pend_data_d;
    if (pend_q) begin
      mem_q[pend_addr_q] <= pend_data_q;
    end
  end

  // Read port is combinational; the owner registers it
  assign rd_data = mem_q[rd_addr];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_commit_next: assert property (
    @(posedge wr_clk) disable iff (wr_reset)
    wr_en |-> ##2 (mem_q[$past(wr_addr, 2)] == $past(wr_data, 2))
  ) else $error("Sampled byte not committed on the following edge");

endmodule
`default_nettype wire

// >>> dld_pin_model.sv
// Far-side pin model: resolves the three-state output bytes
`timescale 1ns/100ps
`default_nettype none

module dld_pin_model (
  input  wire logic               one_oe,
  input  wire dld_pkg::dld_byte_t one_byte,
  input  wire logic               two_oe,
  input  wire dld_pkg::dld_byte_t two_byte,
  output wire dld_pkg::dld_byte_t one_pin,
  output wire dld_pkg::dld_byte_t two_pin
);
  import dld_pkg::*;

  // Undriven pins float, so a stale byte can never pass for data
  assign one_pin = one_oe ? one_byte : 'z;
  assign two_pin = two_oe ? two_byte : 'z;
endmodule

`default_nettype wire

// >>> dld_pkg.sv
// Shared constants and types for the dual line delay FIFO
package dld_pkg;

  // Geometry of each line memory
  localparam int LINE_DEPTH = 5120;
  localparam int LINE_WIDTH = 8;
  localparam int LINE_AW    = $clog2(LINE_DEPTH);

  // Smallest geometry the pointer logic can serve
  localparam int MIN_DEPTH  = 2;
  localparam int MIN_WIDTH  = 1;

  // Synchroniser length for the reset entering the read domain
  localparam int SYNC_STAGES = 2;

  // Byte carried on the data pins
  typedef logic [LINE_WIDTH-1:0] dld_byte_t;

endpackage
